// ==== src/spr_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Mode field decodes idle, noise, powerdown, standby
// - Sleep only when sleep arm set
// - Bit 7 stops pwm stage two clock
// - Bit 5 stops reduced pwm stage clock
// - Bit 4 gates timer one, state kept
// - Bit 2 stops serial port clock
// - Bit 0 stops converter clock
// - Comparator loses converter mux when stopped
// - Any reset loads registers, restarts at vector
// - Ports reset asynchronously on power-on only, other sources synchronised
// - Delay counter stretches reset after release
// - Exactly four reset sources combined
// - Pin disabled by fuse or soft bit
// - Watchdog expiry with enable causes reset
// - Power-on rise delayed, fall immediate
// - Pin low over 400 ns resets
// - Pin release starts delay counter
// - Brown-out asserts after 2 us filter, release delayed
// - Brown-out dips under 2 us ignored
// - Power-down halts all generated clocks
// - Standby wake within six cycles
// - Clearing bit restores clock, state kept
module spr_ctrl
  import spr_pkg::*;
#(
  parameter int TOUT_CYCLES = SPR_TOUT_DEFAULT
)(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [7:0]  haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Core sleep handshake
  input  wire logic        sleep_instr_i,
  input  wire logic        wake_event_i,
  output logic             core_halt_o,
  output logic             io_clk_en_o,
  output logic             osc_run_o,
  // Peripheral clock gates
  output spr_clk_en_t      periph_clk_en_o,
  output logic             comp_mux_allow_o,
  // Reset sources and fuses
  input  wire logic        por_n_i,
  input  wire logic        reset_pin_n_i,
  input  wire logic        wdt_expire_i,
  input  wire logic        wdt_enable_i,
  input  wire logic        bod_low_i,
  input  wire logic        bod_enable_i,
  input  wire logic        reset_pin_fuse_disable_i,
  // Reset outputs
  output logic             io_reset_o,
  output logic             core_reset_o,
  output logic             serial_prog_en_o
);

  typedef struct packed {
    logic [7:0]  sleep_ctl;
    logic [7:0]  power_reduction;
    logic [7:0]  core_ctl;
    spr_state_t  st;
    logic [2:0]  wake_cnt;
    logic        ph_act;
    logic        ph_wr;
    logic [7:0]  ph_addr;
    logic [31:0] rdata;
    logic [1:0]  pin_sync;
    logic [1:0]  bod_sync;
    logic [1:0]  wdt_sync;
    logic [15:0] pin_cnt;
    logic [15:0] bod_cnt;
    logic [31:0] tout_cnt;
    logic        stretch;
  } spr_state_all_t;

  spr_state_all_t s_reg, s_next;
  logic pin_rst, bod_rst, wdt_rst, src_active;

  // Address decode for reads
  function automatic logic [31:0] rd_mux(input logic [7:0] a, input spr_state_all_t s);
    unique case (a)
      SPR_ADDR_SLEEP_CTRL: rd_mux = {24'h00_0000, s.sleep_ctl};
      SPR_ADDR_POWER_RED:  rd_mux = {24'h00_0000, s.power_reduction};
      SPR_ADDR_CORE_CTRL:  rd_mux = {24'h00_0000, s.core_ctl};
      SPR_ADDR_STATUS:     rd_mux = {28'h000_0000, s.stretch, s.st};
      default:             rd_mux = 32'h0000_0000;
    endcase
  endfunction : rd_mux

  // Qualified reset sources, asynchronous paths act on io_reset_o
  assign pin_rst = !s_reg.core_ctl[SPR_RST_SOFT_DIS_BIT] && !reset_pin_fuse_disable_i
                   && (s_reg.pin_cnt >= 16'(SPR_PIN_MIN_CYC));
  assign bod_rst = bod_enable_i && (s_reg.bod_cnt >= 16'(SPR_BOD_MIN_CYC));
  assign wdt_rst = s_reg.wdt_sync[1] && wdt_enable_i;
  assign src_active = !por_n_i || pin_rst || bod_rst || wdt_rst;

  // Next-state logic
  always_comb
  begin
    s_next = s_reg;
    s_next.pin_sync = {s_reg.pin_sync[0], ~reset_pin_n_i};
    s_next.bod_sync = {s_reg.bod_sync[0], bod_low_i};
    s_next.wdt_sync = {s_reg.wdt_sync[0], wdt_expire_i};
    // Pulse-width filters
    if (!s_reg.pin_sync[1])
      s_next.pin_cnt = 16'h0000;
    else if (s_reg.pin_cnt != 16'hFFFF)
      s_next.pin_cnt = s_reg.pin_cnt + 16'h0001;
    if (!s_reg.bod_sync[1])
      s_next.bod_cnt = 16'h0000;
    else if (s_reg.bod_cnt != 16'hFFFF)
      s_next.bod_cnt = s_reg.bod_cnt + 16'h0001;
    // Reset stretch counter
    if (src_active)
    begin
      s_next.stretch  = 1'b1;
      s_next.tout_cnt = 32'h0000_0000;
    end
    else if (s_reg.stretch)
    begin
      if (s_reg.tout_cnt >= 32'(TOUT_CYCLES - 1))
        s_next.stretch = 1'b0;
      else
        s_next.tout_cnt = s_reg.tout_cnt + 32'h0000_0001;
    end
    // AHB data phase
    s_next.rdata = 32'h0000_0000;
    s_next.ph_act = hsel_i && hready_i && htrans_i[1];
    s_next.ph_wr = hwrite_i;
    s_next.ph_addr = haddr_i;
    if (s_reg.ph_act && s_reg.ph_wr)
    begin
      unique case (s_reg.ph_addr)
        SPR_ADDR_SLEEP_CTRL: s_next.sleep_ctl = hwdata_i[7:0] & SPR_SLEEP_MASK;
        SPR_ADDR_POWER_RED:  s_next.power_reduction = hwdata_i[7:0] & SPR_PRR_MASK;
        SPR_ADDR_CORE_CTRL:  s_next.core_ctl = hwdata_i[7:0] & SPR_CORE_MASK;
        default:             s_next.power_reduction = s_next.power_reduction;
      endcase
    end
    if (hsel_i && hready_i && htrans_i[1] && !hwrite_i)
      s_next.rdata = rd_mux(haddr_i, s_reg);
    // Sleep sequencer
    unique case (s_reg.st)
      SPR_RUN:
        if (sleep_instr_i && s_reg.sleep_ctl[SPR_SLEEP_ARM_BIT])
        begin
          unique case (s_reg.sleep_ctl[SPR_MODE_MSB:SPR_MODE_LSB])
            SPR_MODE_IDLE:    s_next.st = SPR_IDLE_SL;
            SPR_MODE_NOISE:   s_next.st = SPR_NOISE_SL;
            SPR_MODE_PDOWN:   s_next.st = SPR_PDOWN_SL;
            SPR_MODE_STANDBY: s_next.st = SPR_STBY_SL;
            default:          s_next.st = SPR_RUN;
          endcase
        end
      SPR_IDLE_SL, SPR_NOISE_SL, SPR_PDOWN_SL:
        if (wake_event_i)
          s_next.st = SPR_RUN;
      SPR_STBY_SL:
        if (wake_event_i)
        begin
          s_next.st = SPR_WAKE;
          s_next.wake_cnt = 3'h0;
        end
      SPR_WAKE:
        if (s_reg.wake_cnt >= 3'(SPR_WAKE_STBY_CYC - 2))
          s_next.st = SPR_RUN;
        else
          s_next.wake_cnt = s_reg.wake_cnt + 3'h1;
      default: s_next.st = SPR_RUN;
    endcase
    // Any reset reloads control registers and sleep state
    if (!resetn_i || src_active || s_reg.stretch)
    begin
      s_next.sleep_ctl = SPR_SLEEP_RESET;
      s_next.power_reduction       = SPR_PRR_RESET;
      s_next.core_ctl  = SPR_CORE_RESET;
      s_next.st        = SPR_RUN;
      s_next.wake_cnt  = 3'h0;
    end
    if (!resetn_i)
    begin
      s_next.ph_act   = 1'b0;
      s_next.rdata    = 32'h0000_0000;
      s_next.pin_sync = 2'h0;
      s_next.bod_sync = 2'h0;
      s_next.wdt_sync = 2'h0;
      s_next.pin_cnt  = 16'h0000;
      s_next.bod_cnt  = 16'h0000;
      s_next.tout_cnt = 32'h0000_0000;
      s_next.stretch  = 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk_i)
  begin
    s_reg <= s_next;
  end

  // Bus answer: zero wait, always OKAY
  assign hrdata_o    = s_reg.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // Reset outputs; ports react combinationally to power-on, other sources registered
  assign io_reset_o       = src_active || !por_n_i || s_reg.stretch;
  assign core_reset_o     = s_reg.stretch;
  assign serial_prog_en_o = !reset_pin_fuse_disable_i;

  // Clock control per sleep state
  assign core_halt_o = (s_reg.st != SPR_RUN);
  assign io_clk_en_o = (s_reg.st == SPR_RUN) || (s_reg.st == SPR_IDLE_SL);
  assign osc_run_o   = (s_reg.st != SPR_PDOWN_SL);

  // Peripheral gates; register content held, so state kept
  always_comb
  begin
    periph_clk_en_o.pwm_stage_two     = io_clk_en_o && !s_reg.power_reduction[SPR_PWM2_BIT];
    periph_clk_en_o.reduced_pwm_stage = io_clk_en_o && !s_reg.power_reduction[SPR_PWMR_BIT];
    periph_clk_en_o.timer_one         = io_clk_en_o && !s_reg.power_reduction[SPR_TIM1_BIT];
    periph_clk_en_o.serial_port       = io_clk_en_o && !s_reg.power_reduction[SPR_SPI_BIT];
    periph_clk_en_o.converter         = (s_reg.st != SPR_PDOWN_SL) && (s_reg.st != SPR_STBY_SL)
                                        && !s_reg.power_reduction[SPR_ADC_BIT];
  end

  assign comp_mux_allow_o = !s_reg.power_reduction[SPR_ADC_BIT];

endmodule : spr_ctrl

`default_nettype wire

// ==== src/spr_pkg.sv ====
package spr_pkg;

  // Register byte addresses (chosen)
  localparam logic [7:0] SPR_ADDR_SLEEP_CTRL = 8'h00;
  localparam logic [7:0] SPR_ADDR_POWER_RED  = 8'h04;
  localparam logic [7:0] SPR_ADDR_CORE_CTRL  = 8'h08;
  localparam logic [7:0] SPR_ADDR_STATUS     = 8'h0C;

  // Field positions
  localparam int SPR_SLEEP_ARM_BIT   = 0;
  localparam int SPR_MODE_LSB        = 1;
  localparam int SPR_MODE_MSB        = 3;
  localparam int SPR_PWM2_BIT        = 7;
  localparam int SPR_PWMR_BIT        = 5;
  localparam int SPR_TIM1_BIT        = 4;
  localparam int SPR_SPI_BIT         = 2;
  localparam int SPR_ADC_BIT         = 0;
  localparam int SPR_RST_SOFT_DIS_BIT = 3;

  // Writable masks and reset values
  localparam logic [7:0] SPR_SLEEP_MASK  = 8'h0F;
  localparam logic [7:0] SPR_PRR_MASK    = 8'hB5;
  localparam logic [7:0] SPR_CORE_MASK   = 8'h08;
  localparam logic [7:0] SPR_SLEEP_RESET = 8'h00;
  localparam logic [7:0] SPR_PRR_RESET   = 8'h00;
  localparam logic [7:0] SPR_CORE_RESET  = 8'h00;

  // Sleep mode encodings
  localparam logic [2:0] SPR_MODE_IDLE    = 3'h0;
  localparam logic [2:0] SPR_MODE_NOISE   = 3'h1;
  localparam logic [2:0] SPR_MODE_PDOWN   = 3'h2;
  localparam logic [2:0] SPR_MODE_STANDBY = 3'h6;

  // Timing
  localparam int SPR_CLK_HZ        = 20_000_000;
  localparam int SPR_PIN_MIN_NS    = 400;
  localparam int SPR_PIN_MIN_CYC   = (SPR_PIN_MIN_NS * (SPR_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SPR_BOD_MIN_US    = 2;
  localparam int SPR_BOD_MIN_CYC   = SPR_BOD_MIN_US * (SPR_CLK_HZ / 1_000_000);
  localparam int SPR_WAKE_STBY_CYC = 6;
  localparam int SPR_TOUT_DEFAULT  = 1024;

  // AHB constants
  localparam logic [1:0] SPR_HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    SPR_RUN, SPR_IDLE_SL, SPR_NOISE_SL, SPR_PDOWN_SL, SPR_STBY_SL, SPR_WAKE
  } spr_state_t;

  // Peripheral clock gates
  typedef struct packed {
    logic pwm_stage_two;
    logic reduced_pwm_stage;
    logic timer_one;
    logic serial_port;
    logic converter;
  } spr_clk_en_t;

endpackage : spr_pkg

// ==== testbench/spr_ctrl_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module spr_ctrl_chk
  import spr_pkg::*;
#(parameter int TOUT_CYCLES = 16)(
  input wire logic sys_clk_i, resetn_i, sleep_instr_i, core_halt_o, io_clk_en_o, osc_run_o,
  input wire logic comp_mux_allow_o, por_n_i, wdt_expire_i, wdt_enable_i, bod_low_i, bod_enable_i,
  input wire logic reset_pin_fuse_disable_i, io_reset_o, core_reset_o, serial_prog_en_o,
  input wire spr_clk_en_t periph_clk_en_o
);
  logic [15:0] quiet_cnt, bod_cnt;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // Quiet time of the power-on, brown-out and watchdog inputs, length of a brown-out dip
  always_ff @(posedge sys_clk_i)
  begin
    quiet_cnt <= (!resetn_i || !por_n_i || bod_low_i || wdt_expire_i) ? 16'h0000 : quiet_cnt + 16'h0001;
    bod_cnt   <= (bod_low_i && bod_enable_i) ? bod_cnt + 16'h0001 : 16'h0000;
  end
  a_prog_follows_fuse:
    assert property (serial_prog_en_o == !reset_pin_fuse_disable_i) else $error("prog enable wrong");
  a_conv_mux_block:
    assert property (!comp_mux_allow_o |-> !periph_clk_en_o.converter) else $error("mux blocked, clock on");
  a_por_io_reset:
    assert property (!por_n_i |-> io_reset_o) else $error("io reset late");
  a_por_core_reset:
    assert property (!por_n_i |=> core_reset_o) else $error("core reset late");
  a_bod_dip_reset:
    assert property (bod_cnt > 16'h002D |-> core_reset_o) else $error("brown-out missed");
  a_stretch_held:
    assert property ($fell(core_reset_o) |-> quiet_cnt >= TOUT_CYCLES) else $error("stretch short");
  a_wdt_reset:
    assert property (wdt_expire_i && wdt_enable_i |-> ##[1:4] core_reset_o) else $error("watchdog missed");
  a_pdown_clocks:
    assert property (!osc_run_o |-> !io_clk_en_o && periph_clk_en_o == '0) else $error("clock in pdown");
  a_halt_cause:
    assert property ($rose(core_halt_o) |-> $past(sleep_instr_i)) else $error("halt without sleep");
  c_release: cover property ($fell(core_reset_o));
  c_pdown: cover property (!osc_run_o);
  c_halt: cover property ($rose(core_halt_o));
endmodule : spr_ctrl_chk
bind spr_ctrl spr_ctrl_chk #(.TOUT_CYCLES(TOUT_CYCLES)) chk (.*);
`default_nettype wire

// ==== testbench/tb_sleep_power_reset_control.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_sleep_power_reset_control;
  import spr_pkg::*;
  // Stimulus and observed signals
  logic        sys_clk_i = 1'b0, resetn_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0, sleep_instr_i = 1'b0;
  logic        wake_event_i = 1'b0, por_n_i = 1'b1, reset_pin_n_i = 1'b1, wdt_expire_i = 1'b0;
  logic        wdt_enable_i = 1'b0, bod_low_i = 1'b0, bod_enable_i = 1'b1, reset_pin_fuse_disable_i = 1'b0;
  logic [7:0]  haddr_i = 8'h00;
  logic [1:0]  htrans_i = 2'h0;
  logic [2:0]  hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0000_0000, hrdata_o, rd, v;
  wire logic   hready_i;
  logic        hreadyout_o, hresp_o, core_halt_o, io_clk_en_o, osc_run_o, comp_mux_allow_o;
  logic        io_reset_o, core_reset_o, serial_prog_en_o, sl;
  spr_clk_en_t periph_clk_en_o;
  int          error_cnt = 0, cmp_count = 0, cyc = 0, seed = 31337;

  assign hready_i = hreadyout_o;
  spr_ctrl #(.TOUT_CYCLES(16)) DUT (.*);

  // Clock and hang guard
  always #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      error_cnt++;
      close_out();
    end
  end

  task close_out;
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : tick

  // Clock gate expected from a power reduction value
  function automatic logic [4:0] gates(input logic [7:0] p);
    return ~{p[7], p[5], p[4], p[2], p[0]};
  endfunction : gates

  // One single AHB transfer; read data lands in rd
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= SPR_HTRANS_NONSEQ;
    // Address phase held until hready is seen at a rising edge
    do @(posedge sys_clk_i); while (hready_i !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    // Data phase; read data and response taken at the same edge
    do @(posedge sys_clk_i); while (hready_i !== 1'b1);
    rd = hrdata_o;
    chk("response", 0, hresp_o);
  endtask : ahb

  // Wait out the stretched reset, checking its length
  task hold(input logic e);
    int n;
    n = 0;
    while (core_reset_o !== 1'b0 && n < 300)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    if (e) chk("stretch length", 1, n >= 15 && n <= 24);
  endtask : hold

  // Source pattern s = {brown-out, watchdog, pin, power-on}
  task rs(input logic [3:0] s, input int len, input logic e);
    ahb(1'b1, SPR_ADDR_POWER_RED, 32'h0000_00FF);
    @(posedge sys_clk_i);
    {bod_low_i, wdt_expire_i, reset_pin_n_i, por_n_i} <= {s[3], s[2], !s[1], !s[0]};
    tick(len);
    @(negedge sys_clk_i) chk("io reset", e, io_reset_o);
    @(posedge sys_clk_i);
    {bod_low_i, wdt_expire_i, reset_pin_n_i, por_n_i} <= 4'h3;
    @(negedge sys_clk_i) chk("core reset", e, core_reset_o);
    hold(e);
    ahb(1'b0, SPR_ADDR_POWER_RED, 32'h0000_0000);
    chk("power reduction", e ? 32'h0000_0000 : 32'h0000_00B5, rd);
  endtask : rs

  // Main sequence
  initial
  begin
    tick(12);
    resetn_i <= 1'b1;
    hold(1'b1);
    for (int a = 0; a < 5; a++)
    begin
      ahb(1'b0, 8'(a * 4), 32'h0000_0000);
      chk("reset value", 0, rd);
    end
    repeat (6)
    begin
      v = $random(seed);
      ahb(1'b1, SPR_ADDR_POWER_RED, v);
      ahb(1'b0, SPR_ADDR_POWER_RED, 32'h0000_0000);
      chk("power reduction", v & 32'h0000_00B5, rd);
      chk("clock gates", 32'(gates(v[7:0])), periph_clk_en_o);
      chk("comparator mux", !v[0], comp_mux_allow_o);
      ahb(1'b1, SPR_ADDR_SLEEP_CTRL, v);
      ahb(1'b0, SPR_ADDR_SLEEP_CTRL, 32'h0000_0000);
      chk("sleep control", v & 32'h0000_000F, rd);
    end
    ahb(1'b1, 8'h10, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped", 0, rd);
    // Every mode code armed, then idle unarmed
    for (int m = 0; m < 9; m++)
    begin
      ahb(1'b1, SPR_ADDR_SLEEP_CTRL, {28'h0, m[2:0], m < 8}); // clock source assumed crystal
      @(posedge sys_clk_i) sleep_instr_i <= 1'b1;
      @(posedge sys_clk_i) sleep_instr_i <= 1'b0;
      tick(2);
      @(negedge sys_clk_i);
      sl = m < 8 && m[2:0] inside {3'h0, 3'h1, 3'h2, 3'h6};
      chk("halt", sl, core_halt_o);
      chk("io clock", !sl || m == 0, io_clk_en_o);
      chk("oscillator", !(sl && m == 2), osc_run_o);
      @(posedge sys_clk_i) wake_event_i <= 1'b1;
      @(posedge sys_clk_i) wake_event_i <= 1'b0;
      tick(5);
      @(negedge sys_clk_i) chk("wake", 0, core_halt_o);
    end
    ahb(1'b1, SPR_ADDR_SLEEP_CTRL, 32'h0000_0000);
    rs(4'h1, 3, 1'b1);
    rs(4'h2, 4, 1'b0);
    rs(4'h2, 14, 1'b1);
    rs(4'h8, 20, 1'b0);
    rs(4'h8, 50, 1'b1);
    rs(4'h4, 6, 1'b0);
    wdt_enable_i <= 1'b1;
    rs(4'h4, 6, 1'b1);
    bod_enable_i <= 1'b0;
    rs(4'h8, 50, 1'b0);
    reset_pin_fuse_disable_i <= 1'b1;
    rs(4'h2, 14, 1'b0);
    chk("serial programming", 0, serial_prog_en_o);
    reset_pin_fuse_disable_i <= 1'b0;
    ahb(1'b1, SPR_ADDR_CORE_CTRL, 32'h0000_0008);
    rs(4'h2, 14, 1'b0);
    close_out();
  end
endmodule : tb_sleep_power_reset_control
`default_nettype wire
